// File: core/ptp_pkg.sv
package ptp_pkg;
  localparam int CLK_HZ = 100_000_000;
  localparam int MAX_BAUD = 115_200;
  localparam int ADDR_W = 8;
  localparam int FIFO_AW = 11;
  localparam logic [7:0] A_CTRL = 8'h00;
  localparam logic [7:0] A_PRM0 = 8'h04;
  localparam logic [7:0] A_PRM1 = 8'h08;
  localparam logic [7:0] A_TXD = 8'h0C;
  localparam logic [7:0] A_RXD = 8'h10;
  localparam logic [7:0] A_STAT = 8'h14;
  localparam logic [1:0] RESP_OK = 2'h0;
  localparam logic [1:0] RESP_ERR = 2'h2;
  localparam logic [31:0] CTRL_RST = 32'h1103_0B01;
  localparam logic [63:0] PRM_RST = 64'hFFFF_FFFF_FFFF_FFFF;
  localparam logic [7:0] CHAR_LIMIT = 8'h20;
  localparam logic [2:0] P_RAW = 3'h1;
  localparam logic [2:0] P_STX = 3'h2;
  localparam logic [2:0] P_3964 = 3'h3;
  localparam logic [2:0] P_MASC = 3'h6;
  localparam logic [1:0] PAR_ODD = 2'h1;
  localparam logic [1:0] PAR_EVEN = 2'h2;
  localparam logic [1:0] STOP_15 = 2'h2;
  localparam logic [3:0] BAUD_MIN = 4'h4;
  localparam logic [3:0] BAUD_MAX = 4'hE;
  localparam logic [2:0] W_ACK3964 = 3'h6;
  localparam logic [2:0] W_GAP = 3'h4;
  localparam logic [2:0] W_RESP = 3'h0;

  typedef struct packed {
    logic [2:0] pad3;
    logic flow;
    logic [1:0] pad2;
    logic [1:0] stop;
    logic [1:0] pad1;
    logic [1:0] par;
    logic [1:0] pad0;
    logic [1:0] clen;
    logic [3:0] padb;
    logic [3:0] baud;
    logic [4:0] padp;
    logic [2:0] proto;
  } ctrl_t;

  typedef struct packed {
    logic [21:0] pad;
    logic perr;
    logic busy;
    logic rx_end;
    logic cfg_err;
    logic rx_ovf;
    logic tx_ovf;
    logic rx_empty;
    logic tx_full;
    logic ack_fail;
    logic ack_ok;
  } status_t;

  typedef enum logic [5:0] {
    PH_IDLE = 6'b000001,
    PH_HEAD = 6'b000010,
    PH_BODY = 6'b000100,
    PH_TAIL = 6'b001000,
    PH_DRAIN = 6'b010000,
    PH_ACKW = 6'b100000
  } phase_t;

  function automatic logic [15:0] baud_hdiv(input logic [3:0] c);
    int b;
    case (c)
      4'h4: b = 1200;
      4'h5: b = 1800;
      4'h6: b = 2400;
      4'h7: b = 4800;
      4'h8: b = 7200;
      4'h9: b = 9600;
      4'hA: b = 14400;
      4'hB: b = 19200;
      4'hC: b = 38400;
      4'hD: b = 57600;
      4'hE: b = MAX_BAUD;
      default: b = 19200;
    endcase
    return 16'(CLK_HZ / (2 * b));
  endfunction : baud_hdiv

  function automatic logic [7:0] char_mask(input logic [1:0] cl);
    return 8'hFF >> (2'h3 - cl);
  endfunction : char_mask

  function automatic logic par_bit(input logic [7:0] d,
                                   input logic [1:0] cl,
                                   input logic [1:0] p);
    logic x;
    x = ^(d & char_mask(cl));
    case (p)
      PAR_ODD: return ~x;
      PAR_EVEN: return x;
      default: return 1'b1;
    endcase
  endfunction : par_bit
endpackage : ptp_pkg

// File: core/char_if.sv
`timescale 1ns/1ps
`default_nettype none
interface char_if;
  logic [15:0] hdiv;
  logic [1:0] clen;
  logic [1:0] par;
  logic [1:0] stop;
  logic [7:0] tdata;
  logic tvalid;
  logic tbusy;
  logic txd;
  logic rxd;
  logic [7:0] rdata;
  logic rvalid;
  logic rperr;
  modport core(output hdiv, clen, par, stop, tdata, tvalid, rxd,
               input tbusy, txd, rdata, rvalid, rperr);
  modport tx(input hdiv, clen, par, stop, tdata, tvalid,
             output tbusy, txd);
  modport rx(input hdiv, clen, par, rxd,
             output rdata, rvalid, rperr);
endinterface : char_if
`default_nettype wire

// File: core/char_tx.sv
`timescale 1ns/1ps
`default_nettype none
module char_tx (
  input wire logic aclk,
  input wire logic aresetn,
  char_if.tx ch
);
  typedef struct packed {
    logic busy;
    logic half;
    logic [4:0] hc;
    logic [15:0] dc;
    logic [11:0] sh;
  } tx_t;
  tx_t s_reg;
  tx_t s_next;
  logic [3:0] nb;

  assign ch.tbusy = s_reg.busy;
  assign ch.txd = s_reg.sh[0];

  always_comb begin
    s_next = s_reg;
    nb = 4'h5 + {2'h0, ch.clen};
    if (!s_reg.busy) begin
      if (ch.tvalid) begin
        s_next.busy = 1'b1;
        s_next.half = 1'b0;
        s_next.dc = 16'h0000;
        s_next.sh = 12'hFFF;
        s_next.sh[0] = 1'b0;
        for (int i = 0; i < 8; i++) begin
          if (i < int'(nb)) begin
            s_next.sh[i + 1] = ch.tdata[i];
          end
        end
        s_next.sh[4'(nb + 4'h1)] = ptp_pkg::par_bit(ch.tdata, ch.clen,
                                                 ch.par);
        // Halves: two per start, data and parity bit, then stop code + 1
        s_next.hc = {nb, 1'b0} + 5'h5 + {3'h0, ch.stop};
      end
    end else if (s_reg.dc == ch.hdiv - 16'h0001) begin
      s_next.dc = 16'h0000;
      s_next.half = !s_reg.half;
      s_next.hc = s_reg.hc - 5'h01;
      if (s_reg.half) begin
        s_next.sh = {1'b1, s_reg.sh[11:1]};
      end
      if (s_reg.hc == 5'h01) begin
        s_next.busy = 1'b0;
      end
    end else begin
      s_next.dc = s_reg.dc + 16'h0001;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_reg <= '{busy: 1'b0, half: 1'b0, hc: 5'h00, dc: 16'h0000,
                 sh: 12'hFFF};
    end else begin
      s_reg <= s_next;
    end
  end
endmodule : char_tx
`default_nettype wire

// File: core/char_rx.sv
`timescale 1ns/1ps
`default_nettype none
module char_rx (
  input wire logic aclk,
  input wire logic aresetn,
  char_if.rx ch
);
  typedef struct packed {
    logic act;
    logic prev;
    logic [3:0] k;
    logic [16:0] dc;
    logic [8:0] sh;
    logic [7:0] rd;
    logic rv;
    logic pe;
  } rx_t;
  rx_t s_reg;
  rx_t s_next;
  logic [3:0] nb;
  logic [16:0] tgt;

  assign ch.rdata = s_reg.rd;
  assign ch.rvalid = s_reg.rv;
  assign ch.rperr = s_reg.pe;

  always_comb begin
    s_next = s_reg;
    s_next.rv = 1'b0;
    s_next.prev = ch.rxd;
    nb = 4'h5 + {2'h0, ch.clen};
    // Start bit sampled mid-bit, later bits one full bit apart
    tgt = (s_reg.k == 4'h0) ? {1'b0, ch.hdiv} - 17'h1
                            : {ch.hdiv, 1'b0} - 17'h1;
    if (!s_reg.act) begin
      if (s_reg.prev && !ch.rxd) begin
        s_next.act = 1'b1;
        s_next.k = 4'h0;
        s_next.dc = 17'h0;
      end
    end else if (s_reg.dc == tgt) begin
      s_next.dc = 17'h0;
      s_next.k = s_reg.k + 4'h1;
      if (s_reg.k == 4'h0) begin
        if (ch.rxd) begin
          s_next.act = 1'b0;
        end
      end else begin
        s_next.sh[4'(s_reg.k - 4'h1)] = ch.rxd;
      end
      if (s_reg.k == nb + 4'h1) begin
        s_next.act = 1'b0;
        s_next.rv = 1'b1;
        s_next.rd = s_next.sh[7:0] & ptp_pkg::char_mask(ch.clen);
        // Parity position is always present but only judged when enabled
        s_next.pe = (ch.par == ptp_pkg::PAR_ODD ||
                     ch.par == ptp_pkg::PAR_EVEN) &&
                    (s_next.sh[nb] != ptp_pkg::par_bit(s_next.rd,
                     ch.clen, ch.par));
      end
    end else begin
      s_next.dc = s_reg.dc + 17'h1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_reg <= '{act: 1'b0, prev: 1'b1, k: 4'h0, dc: 17'h0,
                 sh: 9'h000, rd: 8'h00, rv: 1'b0, pe: 1'b0};
    end else begin
      s_reg <= s_next;
    end
  end
endmodule : char_rx
`default_nettype wire

// File: core/rs485_ptp_serial_port.sv
// Contract
// - Host bytes queue in a 2x1024 send FIFO and go out in order.
// - Each received byte enters a 2x1024 receive FIFO for the host unless the FIFO is full (then rx_ovf is set).
// - Only STX/ETX gets its framing (start and end characters) added by hardware.
// - 3964R, USS, Modbus wait for partner acknowledgement; raw, STX/ETX do not.
// - Half duplex: never transmit and receive at the same time.
// - Bit rate never exceeds 115.2 kbaud.
// - Protocol code 1..6: raw, STX/ETX, 3964R, USS, Modbus RTU, ASCII.
// - Baud codes 04h..0Eh select 1200 up to 115200 baud.
// - Length code 0..3 selects five to eight data bits.
// - Parity code 0 none, 1 odd, 2 even, bit after data.
// - With no parity a one is sent and ignored on receive.
// - Stop code 1, 2, 3 gives one, one and a half, two bits.
// - One and a half stop bits only with five data bits.
// - Request-to-send high while sending, low while receiving; flow fixed 1.
// - Raw mode ignores the protocol parameter block.
// - STX/ETX: start chars bytes 0,1, end chars 2,3, gap word 4.
// - Start or end character used only when below 20h.
// - 3964R: priority, tries, retries, char and ack timeouts; priorities differ. Only the ack timeout, word 6, is used.
// - USS and Modbus take response timeout from word 0.
// - Timeouts count bit times of the selected baud rate.
`timescale 1ns/1ps
`default_nettype none
module rs485_ptp_serial_port #(
  parameter int FIFO_AW = ptp_pkg::FIFO_AW
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [ptp_pkg::ADDR_W-1:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [ptp_pkg::ADDR_W-1:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  input wire logic line_in,
  output logic line_out,
  output logic line_oe_n,
  output logic rts
);
  localparam int PW = FIFO_AW + 1;

  typedef struct packed {
    logic [7:0] awa;
    logic awv;
    logic [31:0] wd;
    logic [3:0] ws;
    logic wv;
    logic awr;
    logic wr;
    logic bv;
    logic [1:0] br;
    logic arr;
    logic rv;
    logic [1:0] rr;
    logic [31:0] rd;
    ptp_pkg::ctrl_t cfg;
    logic [63:0] prm;
    ptp_pkg::status_t st;
    logic s1;
    logic s2;
    logic [PW-1:0] tw;
    logic [PW-1:0] tr;
    logic [PW-1:0] rw;
    logic [PW-1:0] rp;
    ptp_pkg::phase_t ph;
    logic idx;
    logic [16:0] tk;
    logic [15:0] tmo;
    logic rxg;
    logic rts;
    logic oen;
  } top_t;

  top_t s_reg;
  top_t s_next;
  logic [7:0] txm [2**FIFO_AW];
  logic [8:0] rxm [2**FIFO_AW];
  logic tx_we;
  logic rx_we;
  logic tx_empty;
  logic tx_full;
  logic rx_empty;
  logic rx_full;
  logic btick;
  logic ack_mode;
  logic [7:0] ch_sel;
  logic [15:0] limit;
  logic [31:0] cand;

  char_if ch();

  char_tx u_tx (
    .aclk(aclk),
    .aresetn(aresetn),
    .ch(ch)
  );

  char_rx u_rx (
    .aclk(aclk),
    .aresetn(aresetn),
    .ch(ch)
  );

  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] nw,
                                        input logic [3:0] be);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        r[8*i +: 8] = nw[8*i +: 8];
      end
    end
    return r;
  endfunction : merge

  function automatic logic [15:0] pword(input logic [63:0] p,
                                        input logic [2:0] b);
    return {p[{b, 3'h0} +: 8], p[{b + 3'h1, 3'h0} +: 8]};
  endfunction : pword

  function automatic logic ptr_full(input logic [PW-1:0] a,
                                    input logic [PW-1:0] b);
    return (a ^ b) == {1'b1, {FIFO_AW{1'b0}}};
  endfunction : ptr_full

  function automatic logic cfg_ok(input ptp_pkg::ctrl_t c);
    return c.proto >= ptp_pkg::P_RAW && c.proto <= ptp_pkg::P_MASC &&
           c.baud >= ptp_pkg::BAUD_MIN && c.baud <= ptp_pkg::BAUD_MAX &&
           c.par != 2'h3 && c.stop != 2'h0 &&
           !(c.stop == ptp_pkg::STOP_15 && c.clen != 2'h0);
  endfunction : cfg_ok

  assign awready = s_reg.awr;
  assign wready = s_reg.wr;
  assign bvalid = s_reg.bv;
  assign bresp = s_reg.br;
  assign arready = s_reg.arr;
  assign rvalid = s_reg.rv;
  assign rresp = s_reg.rr;
  assign rdata = s_reg.rd;
  assign line_out = ch.txd;
  assign line_oe_n = s_reg.oen;
  assign rts = s_reg.rts;

  assign ch.hdiv = ptp_pkg::baud_hdiv(s_reg.cfg.baud);
  assign ch.clen = s_reg.cfg.clen;
  assign ch.par = s_reg.cfg.par;
  assign ch.stop = s_reg.cfg.stop;
  // Receiver sees an idle line while we drive the pair
  assign ch.rxd = s_reg.oen ? s_reg.s2 : 1'b1;

  assign tx_empty = s_reg.tw == s_reg.tr;
  assign tx_full = ptr_full(s_reg.tw, s_reg.tr);
  assign rx_empty = s_reg.rw == s_reg.rp;
  assign rx_full = ptr_full(s_reg.rw, s_reg.rp);
  assign btick = s_reg.tk == {ch.hdiv, 1'b0} - 17'h1;
  assign ack_mode = s_reg.cfg.proto >= ptp_pkg::P_3964;
  assign limit = (s_reg.cfg.proto == ptp_pkg::P_3964)
               ? pword(s_reg.prm, ptp_pkg::W_ACK3964)
               : pword(s_reg.prm, ptp_pkg::W_RESP);

  always_ff @(posedge aclk) begin
    if (tx_we) begin
      txm[s_reg.tw[FIFO_AW-1:0]] <= s_reg.wd[7:0];
    end
    if (rx_we) begin
      rxm[s_reg.rw[FIFO_AW-1:0]] <= {ch.rperr, ch.rdata};
    end
  end

  always_comb begin
    s_next = s_reg;
    tx_we = 1'b0;
    rx_we = 1'b0;
    cand = merge(s_reg.cfg, s_reg.wd, s_reg.ws);
    ch.tvalid = 1'b0;
    ch.tdata = txm[s_reg.tr[FIFO_AW-1:0]];
    ch_sel = s_reg.prm[{s_reg.ph == ptp_pkg::PH_TAIL, s_reg.idx, 3'h0} +: 8];
    s_next.s1 = line_in;
    s_next.s2 = s_reg.s1;
    s_next.tk = btick ? 17'h0 : s_reg.tk + 17'h1;

    if (awvalid && s_reg.awr) begin
      s_next.awa = awaddr;
      s_next.awv = 1'b1;
    end
    if (wvalid && s_reg.wr) begin
      s_next.wd = wdata;
      s_next.ws = wstrb;
      s_next.wv = 1'b1;
    end
    if (bready && s_reg.bv) begin
      s_next.bv = 1'b0;
    end
    if (s_reg.awv && s_reg.wv && !s_reg.bv) begin
      s_next.awv = 1'b0;
      s_next.wv = 1'b0;
      s_next.bv = 1'b1;
      s_next.br = ptp_pkg::RESP_OK;
      case (s_reg.awa)
        ptp_pkg::A_CTRL: begin
          if (cfg_ok(cand)) begin
            s_next.cfg = cand & ptp_pkg::CTRL_RST | 32'h0333_0F07;
            s_next.cfg = cand & 32'h0333_0F07;
            s_next.cfg.flow = 1'b1;
          end else begin
            s_next.st.cfg_err = 1'b1;
          end
        end
        ptp_pkg::A_PRM0: begin
          s_next.prm[31:0] = merge(s_reg.prm[31:0], s_reg.wd, s_reg.ws);
        end
        ptp_pkg::A_PRM1: begin
          s_next.prm[63:32] = merge(s_reg.prm[63:32], s_reg.wd, s_reg.ws);
        end
        ptp_pkg::A_TXD: begin
          if (s_reg.ws[0]) begin
            if (tx_full) begin
              s_next.st.tx_ovf = 1'b1;
            end else begin
              tx_we = 1'b1;
              s_next.tw = s_reg.tw + 1'b1;
            end
          end
        end
        ptp_pkg::A_STAT: begin
          // Write one to clear; any set below in this cycle still wins
          s_next.st = s_reg.st & ~(s_reg.wd & {32{s_reg.ws[0]}});
        end
        default: begin
          s_next.br = ptp_pkg::RESP_ERR;
        end
      endcase
    end

    if (rready && s_reg.rv) begin
      s_next.rv = 1'b0;
    end
    if (arvalid && s_reg.arr) begin
      s_next.rv = 1'b1;
      s_next.rr = ptp_pkg::RESP_OK;
      s_next.rd = 32'h0000_0000;
      case (araddr)
        ptp_pkg::A_CTRL: s_next.rd = s_reg.cfg;
        ptp_pkg::A_PRM0: s_next.rd = s_reg.prm[31:0];
        ptp_pkg::A_PRM1: s_next.rd = s_reg.prm[63:32];
        ptp_pkg::A_TXD: s_next.rd = 32'h0000_0000;
        ptp_pkg::A_STAT: s_next.rd = s_reg.st;
        ptp_pkg::A_RXD: begin
          if (!rx_empty) begin
            s_next.rd = {22'h0, 1'b1, rxm[s_reg.rp[FIFO_AW-1:0]]};
            s_next.rp = s_reg.rp + 1'b1;
          end
        end
        default: s_next.rr = ptp_pkg::RESP_ERR;
      endcase
    end

    if (ch.rvalid) begin
      if (rx_full) begin
        s_next.st.rx_ovf = 1'b1;
      end else begin
        rx_we = 1'b1;
        s_next.rw = s_reg.rw + 1'b1;
        s_next.st.perr = s_next.st.perr | ch.rperr;
      end
    end

    case (s_reg.ph)
      ptp_pkg::PH_IDLE: begin
        if (!tx_empty) begin
          s_next.rts = 1'b1;
          s_next.oen = 1'b0;
          s_next.idx = 1'b0;
          s_next.ph = (s_reg.cfg.proto == ptp_pkg::P_STX)
                    ? ptp_pkg::PH_HEAD : ptp_pkg::PH_BODY;
        end else if (s_reg.cfg.proto == ptp_pkg::P_STX) begin
          // End of a received telegram after a quiet gap
          if (ch.rvalid) begin
            s_next.rxg = 1'b1;
            s_next.tmo = 16'h0000;
          end else if (btick && s_reg.rxg) begin
            s_next.tmo = s_reg.tmo + 16'h0001;
            if (s_next.tmo >= pword(s_reg.prm, ptp_pkg::W_GAP)) begin
              s_next.st.rx_end = 1'b1;
              s_next.rxg = 1'b0;
            end
          end
        end
      end
      ptp_pkg::PH_HEAD, ptp_pkg::PH_TAIL: begin
        if (ch_sel < ptp_pkg::CHAR_LIMIT) begin
          ch.tvalid = 1'b1;
          ch.tdata = ch_sel;
        end
        if (!(ch.tvalid && ch.tbusy)) begin
          s_next.idx = !s_reg.idx;
          if (s_reg.idx) begin
            s_next.ph = (s_reg.ph == ptp_pkg::PH_HEAD)
                      ? ptp_pkg::PH_BODY : ptp_pkg::PH_DRAIN;
          end
        end
      end
      ptp_pkg::PH_BODY: begin
        if (!tx_empty) begin
          ch.tvalid = 1'b1;
          if (!ch.tbusy) begin
            s_next.tr = s_reg.tr + 1'b1;
          end
        end else if (!ch.tbusy) begin
          s_next.idx = 1'b0;
          s_next.ph = (s_reg.cfg.proto == ptp_pkg::P_STX)
                    ? ptp_pkg::PH_TAIL : ptp_pkg::PH_DRAIN;
        end
      end
      ptp_pkg::PH_DRAIN: begin
        // Hold the driver until the last stop bit has left
        if (!ch.tbusy) begin
          s_next.rts = 1'b0;
          s_next.oen = 1'b1;
          s_next.tmo = 16'h0000;
          s_next.rxg = 1'b0;
          s_next.ph = ack_mode ? ptp_pkg::PH_ACKW : ptp_pkg::PH_IDLE;
        end
      end
      ptp_pkg::PH_ACKW: begin
        if (ch.rvalid) begin
          s_next.st.ack_ok = 1'b1;
          s_next.ph = ptp_pkg::PH_IDLE;
        end else if (btick) begin
          s_next.tmo = s_reg.tmo + 16'h0001;
          if (s_next.tmo >= limit) begin
            s_next.st.ack_fail = 1'b1;
            s_next.ph = ptp_pkg::PH_IDLE;
          end
        end
      end
      default: begin
        s_next.ph = ptp_pkg::PH_IDLE;
      end
    endcase

    s_next.st.tx_full = ptr_full(s_next.tw, s_next.tr);
    s_next.st.rx_empty = s_next.rw == s_next.rp;
    s_next.st.busy = s_next.ph != ptp_pkg::PH_IDLE;
    s_next.st.pad = 22'h0;
    s_next.awr = !s_next.awv;
    s_next.wr = !s_next.wv;
    s_next.arr = !s_next.rv;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_reg <= '0;
      s_reg.cfg <= ptp_pkg::CTRL_RST;
      s_reg.prm <= ptp_pkg::PRM_RST;
      s_reg.st.rx_empty <= 1'b1;
      s_reg.s1 <= 1'b1;
      s_reg.s2 <= 1'b1;
      s_reg.ph <= ptp_pkg::PH_IDLE;
      s_reg.oen <= 1'b1;
      s_reg.awr <= 1'b1;
      s_reg.wr <= 1'b1;
      s_reg.arr <= 1'b1;
    end else begin
      s_reg <= s_next;
    end
  end
endmodule : rs485_ptp_serial_port
`default_nettype wire

// File: bench/ptp_chk.sv
`timescale 1ns/1ps
`default_nettype none
module ptp_chk (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic awvalid,
  input wire logic awready,
  input wire logic wvalid,
  input wire logic wready,
  input wire logic [1:0] bresp,
  input wire logic bvalid,
  input wire logic bready,
  input wire logic arvalid,
  input wire logic arready,
  input wire logic [31:0] rdata,
  input wire logic rvalid,
  input wire logic rready,
  input wire logic line_in,
  input wire logic line_out,
  input wire logic line_oe_n,
  input wire logic rts
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  property p_wans;
    awvalid && awready && wvalid && wready |-> ##[1:2] bvalid;
  endproperty
  a_wans: assert property (p_wans) else $error("write unanswered");
  property p_bhold;
    bvalid && !bready |=> bvalid && $stable(bresp);
  endproperty
  a_bhold: assert property (p_bhold) else $error("bresp dropped");
  property p_rans;
    arvalid && arready |-> ##[1:2] rvalid;
  endproperty
  a_rans: assert property (p_rans) else $error("read unanswered");
  property p_rhold;
    rvalid && !rready |=> rvalid && $stable(rdata);
  endproperty
  a_rhold: assert property (p_rhold) else $error("rdata dropped");
  property p_rts;
    rts |-> !line_oe_n;
  endproperty
  a_rts: assert property (p_rts) else $error("rts without drive");
  property p_idle;
    line_oe_n |-> line_out;
  endproperty
  a_idle: assert property (p_idle) else $error("idle not high");
  property p_lead;
    $fell(line_oe_n) |-> line_out;
  endproperty
  a_lead: assert property (p_lead) else $error("no lead cycle");
  // Eight cycles is far below any legal bit time, so it never misfires
  property p_start;
    $fell(line_out) |-> (!line_oe_n && !line_out) [*8];
  endproperty
  a_start: assert property (p_start) else $error("start too short");
  c_tx: cover property ($fell(line_out));
  c_wr: cover property (bvalid && bready);
  c_rx: cover property (rvalid && rready && rdata[9]);
endmodule : ptp_chk
bind rs485_ptp_serial_port ptp_chk u_chk (.aclk(aclk), .aresetn(aresetn),
  .awvalid(awvalid), .awready(awready), .wvalid(wvalid), .wready(wready),
  .bresp(bresp), .bvalid(bvalid), .bready(bready), .arvalid(arvalid),
  .arready(arready), .rdata(rdata), .rvalid(rvalid), .rready(rready),
  .line_in(line_in), .line_out(line_out), .line_oe_n(line_oe_n),
  .rts(rts));
`default_nettype wire

// File: bench/far_station.sv
`timescale 1ns/1ps
`default_nettype none
module far_station #(
  parameter int BT = 868
) (
  input wire logic aclk,
  input wire logic line_out,
  input wire logic line_oe_n,
  output logic line_in
);
  logic drv = 1'b1;
  // Bias resistors hold the pair high when neither end drives it
  assign line_in = line_oe_n ? drv : line_out;
  task automatic send(input logic [7:0] d, input int l, input logic p);
    wait (line_oe_n === 1'b1);
    @(posedge aclk);
    drv <= 1'b0;
    repeat (BT) @(posedge aclk);
    for (int i = 0; i < l; i++) begin
      drv <= d[i];
      repeat (BT) @(posedge aclk);
    end
    drv <= p;
    repeat (BT) @(posedge aclk);
    drv <= 1'b1;
    repeat (BT) @(posedge aclk);
  endtask : send
endmodule : far_station
`default_nettype wire

// File: bench/test_rs485_ptp_serial_port.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin \
  cmp_count++; \
  if ((g) !== (e)) begin \
    n_errors++; \
    $display("[ERR] %0t got %h exp %h", $time, g, e); \
  end \
end
module test_rs485_ptp_serial_port;
  localparam int BT = 2 * (ptp_pkg::CLK_HZ / (2 * 115200));
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [7:0] awaddr = 8'h00;
  logic [7:0] araddr = 8'h00;
  logic awvalid = 1'b0;
  logic wvalid = 1'b0;
  logic bready = 1'b0;
  logic arvalid = 1'b0;
  logic rready = 1'b0;
  logic [31:0] wdata = 32'h0;
  logic [3:0] wstrb = 4'hF;
  logic awready, wready, bvalid, arready, rvalid;
  logic line_in, line_out, line_oe_n, rts;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  int n_errors = 0;
  int cmp_count = 0;
  int cyc = 0;
  rs485_ptp_serial_port #(.FIFO_AW(4)) i_dut (.aclk(aclk),
    .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid),
    .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid),
    .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
    .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata),
    .rresp(rresp), .rvalid(rvalid), .rready(rready), .line_in(line_in),
    .line_out(line_out), .line_oe_n(line_oe_n), .rts(rts));
  far_station #(.BT(BT)) i_far (.aclk(aclk), .line_out(line_out),
    .line_oe_n(line_oe_n), .line_in(line_in));
  always #5 aclk = ~aclk;
  task automatic report_and_stop;
    $display("errors %0d compares %0d", n_errors, cmp_count);
    if (n_errors == 0 && cmp_count > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : report_and_stop
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (cyc == 120000) begin
      n_errors++;
      report_and_stop;
    end
  end
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    forever begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      if (bvalid) begin
        bready <= 1'b0;
        break;
      end
    end
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [31:0] d,
                    output logic [1:0] r);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    forever begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
      if (rvalid) begin
        d = rdata;
        r = rresp;
        rready <= 1'b0;
        break;
      end
    end
  endtask : rd
  function automatic logic [31:0] cfg(input logic [2:0] pr,
    input logic [3:0] bd, input logic [1:0] cl, pa, st);
    return {3'h0, 1'b1, 2'h0, st, 2'h0, pa, 2'h0, cl, 4'h0, bd, 5'h0, pr};
  endfunction : cfg
  function automatic logic [11:0] fr(input logic [7:0] d, input int l,
                                     input int p);
    logic [11:0] b;
    logic x;
    x = ^(d & (8'hFF >> (8 - l)));
    b = 12'hFFF;
    b[0] = 1'b0;
    for (int i = 0; i < l; i++) b[i + 1] = d[i];
    b[l + 1] = (p == 1) ? ~x : (p == 2) ? x : 1'b1;
    return b;
  endfunction : fr
  // Samples mid-bit up to the first stop bit, so back-to-back frames match
  task automatic cap(input int n, output logic [11:0] b);
    int k;
    b = 12'hFFF;
    k = 0;
    while (line_out !== 1'b0 && k < 4000) begin
      @(posedge aclk);
      k++;
    end
    `CHK(line_out, 1'b0)
    `CHK(rts, 1'b1)
    repeat (BT / 2) @(posedge aclk);
    for (int i = 0; i < n; i++) begin
      b[i] = line_out;
      if (i < n - 1) repeat (BT) @(posedge aclk);
    end
  endtask : cap
  task automatic t_reset;
    logic [31:0] d;
    logic [1:0] r;
    rd(ptp_pkg::A_CTRL, d, r);
    `CHK(d, 32'h1103_0B01)
    rd(ptp_pkg::A_PRM0, d, r);
    `CHK(d, 32'hFFFF_FFFF)
    rd(ptp_pkg::A_STAT, d, r);
    `CHK(d, 32'h0000_0008)
    rd(8'h18, d, r);
    `CHK(r, ptp_pkg::RESP_ERR)
  endtask : t_reset
  task automatic t_cfg;
    logic [31:0] d;
    logic [1:0] r;
    logic [31:0] bad [5];
    bad = '{cfg(1, 4'hE, 3, 0, 2), cfg(1, 4'hF, 3, 0, 1),
            cfg(7, 4'hB, 3, 0, 1), cfg(1, 4'hB, 3, 3, 1),
            cfg(1, 4'hB, 3, 0, 0)};
    for (int i = 0; i < 5; i++) begin
      wr(ptp_pkg::A_CTRL, bad[i]);
      rd(ptp_pkg::A_CTRL, d, r);
      `CHK(d, 32'h1103_0B01)
    end
    rd(ptp_pkg::A_STAT, d, r);
    `CHK(d[6], 1'b1)
    for (int p = 1; p < 7; p++) begin
      wr(ptp_pkg::A_CTRL, cfg(3'(p), 4'(p + 3), 0, 0, 2));
      rd(ptp_pkg::A_CTRL, d, r);
      `CHK(d, cfg(3'(p), 4'(p + 3), 0, 0, 2))
    end
  endtask : t_cfg
  task automatic t_tx8;
    logic [11:0] b;
    wr(ptp_pkg::A_CTRL, cfg(1, 4'hE, 3, 2, 1));
    wr(ptp_pkg::A_TXD, 32'hA5);
    cap(11, b);
    `CHK(b, fr(8'hA5, 8, 2))
    repeat (BT) @(posedge aclk);
    `CHK(rts, 1'b0)
  endtask : t_tx8
  task automatic t_rx;
    logic [31:0] d;
    logic [1:0] r;
    wr(ptp_pkg::A_CTRL, cfg(1, 4'hE, 3, 1, 1));
    i_far.send(8'h3C, 8, 1'b1);
    repeat (20) @(posedge aclk);
    rd(ptp_pkg::A_RXD, d, r);
    `CHK(d, 32'h23C)
    i_far.send(8'h3C, 8, 1'b0);
    repeat (20) @(posedge aclk);
    rd(ptp_pkg::A_RXD, d, r);
    `CHK(d, 32'h33C)
    rd(ptp_pkg::A_STAT, d, r);
    `CHK(d[3], 1'b1)
  endtask : t_rx
  task automatic t_stx;
    logic [11:0] b;
    logic [7:0] e [3];
    int lo;
    e = '{8'h02, 8'h41, 8'h03};
    lo = 0;
    wr(ptp_pkg::A_PRM0, 32'h2503_FF02);
    wr(ptp_pkg::A_CTRL, cfg(2, 4'hE, 3, 2, 1));
    wr(ptp_pkg::A_TXD, 32'h41);
    for (int i = 0; i < 3; i++) begin
      cap(11, b);
      `CHK(b, fr(e[i], 8, 2))
    end
    repeat (2 * BT) begin
      @(posedge aclk);
      if (!line_out) lo++;
    end
    `CHK(lo, 0)
  endtask : t_stx
  task automatic t_tx5;
    logic [11:0] b;
    wr(ptp_pkg::A_CTRL, cfg(1, 4'hE, 0, 0, 2));
    wr(ptp_pkg::A_TXD, 32'h13);
    cap(8, b);
    `CHK(b, fr(8'h13, 5, 0))
  endtask : t_tx5
  task automatic t_ack;
    logic [11:0] b;
    logic [31:0] d;
    logic [1:0] r;
    wr(ptp_pkg::A_PRM0, 32'hFFFF_0500);
    wr(ptp_pkg::A_STAT, 32'h3FF);
    wr(ptp_pkg::A_CTRL, cfg(5, 4'hE, 3, 0, 1));
    wr(ptp_pkg::A_TXD, 32'h55);
    cap(11, b);
    `CHK(b, fr(8'h55, 8, 0))
    repeat (2 * BT) @(posedge aclk);
    rd(ptp_pkg::A_STAT, d, r);
    `CHK(d[1:0], 2'b00)
    repeat (5 * BT) @(posedge aclk);
    rd(ptp_pkg::A_STAT, d, r);
    `CHK(d[1:0], 2'b10)
  endtask : t_ack
  initial begin
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    t_reset;
    t_cfg;
    t_tx8;
    t_rx;
    t_stx;
    t_tx5;
    t_ack;
    report_and_stop;
  end
endmodule : test_rs485_ptp_serial_port
`default_nettype wire
